// >>> adcsr_host.sv
// host model clocking result frames out
`timescale 1ns/1ns
module adcsr_host (
	// clock
	input wire logic        clock,
	// wire levels
	input wire logic        sck_wire,
	input wire logic        sdo_wire,
	// host drive and result
	output logic            sck_drv,
	output logic     [23:0] frame,
	output logic            done
);
	initial begin
		sck_drv = 0;
		frame = 0;
		done = 0;
	end
	task automatic xfer(input int n, input bit ext);
		logic last;
		frame = 0;
		last = sck_wire;
		for (int i = 1; i < 40000 && n > 0; i++) begin
			@(negedge clock);
			if (sck_wire && !last) begin
				frame = {frame[22:0], sdo_wire};
				n--;
			end
			last = sck_wire;
			if (ext && i % 8 == 0) sck_drv = !sck_drv;
		end
		sck_drv = 0;
		done = 1;
		@(negedge clock);
		done = 0;
	endtask : xfer
endmodule : adcsr_host

// >>> adcsr_pkg.sv
// shared constants and the conversion clock selector of the serial readout block
`timescale 1ns/1ns
package adcsr_pkg;
	typedef enum logic [1:0] {
		ADCSR_CONVERT = 2'b00,
		ADCSR_SLEEP   = 2'b01,
		ADCSR_OUTPUT  = 2'b11
	} adcsr_state_type;

	localparam int          CLK_PERIOD_NS      = 100;
	localparam int          CONV_TIME_60_US    = 133530;
	localparam int          CONV_TIME_50_US    = 160230;
	localparam int          CONV_CYC_60        = CONV_TIME_60_US * 1000 / CLK_PERIOD_NS;
	localparam int          CONV_CYC_50        = CONV_TIME_50_US * 1000 / CLK_PERIOD_NS;
	localparam int          NOTCH_DIV          = 2560;
	localparam int          EXT_CONV_EDGES     = 20510;
	localparam int          ISCK_FREQ_HZ       = 19200;
	localparam int          ISCK_HALF_CYC      = 1000000000 / (CLK_PERIOD_NS * 2 * ISCK_FREQ_HZ);
	localparam int          EXT_ISCK_DIV       = 8;
	localparam int          EXT_ISCK_HALF      = EXT_ISCK_DIV / 2;
	localparam int          OSC_HIGH_MAX_NS    = 200000;
	localparam int          OSC_STATIC_CYC     = 2 * OSC_HIGH_MAX_NS / CLK_PERIOD_NS;
	localparam int          CONV_CNT_W         = 21;
	localparam int          DIV_CNT_W          = 9;
	localparam int          STATIC_CNT_W       = 12;
	localparam int          FRAME_BITS         = 24;
	localparam int          FRAME_MSB          = FRAME_BITS - 1;
	localparam int          RESULT_BITS        = 21;
	localparam logic [4:0]  LAST_BIT_IDX       = 5'(FRAME_BITS - 1);
	localparam logic        FRAME_FILL_BIT     = 1'b0;
	localparam logic [1:0]  STRAP_SETTLE       = 2'h3;
endpackage : adcsr_pkg

module adcsr_freq_sel (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// frequency control pin
	input  wire logic notch_freq_control,
	// decoded choice
	output logic      ext_osc_mode,
	output logic      notch_50hz,
	output logic      osc_edge
);
	import adcsr_pkg::*;

	logic                    f0_s1_reg;
	logic                    f0_s2_reg;
	logic                    f0_s3_reg;
	logic [STATIC_CNT_W-1:0] quiet_cnt_reg;

	// pin synchroniser
	always_ff @(posedge clock) begin
		f0_s1_reg <= notch_freq_control;
		f0_s2_reg <= f0_s1_reg;
		f0_s3_reg <= f0_s2_reg;
	end

	// toggling pin means external system clock
	always_ff @(posedge clock) begin
		if (rst) begin
			quiet_cnt_reg <= '0;
			ext_osc_mode  <= 1'b0;
			osc_edge      <= 1'b0;
			notch_50hz    <= 1'b0;
		end else begin
			osc_edge   <= f0_s2_reg && !f0_s3_reg; // R12
			notch_50hz <= f0_s2_reg; // R10 R11
			if (f0_s2_reg != f0_s3_reg) begin
				quiet_cnt_reg <= '0;
				ext_osc_mode  <= 1'b1; // R12
			end else if (quiet_cnt_reg == STATIC_CNT_W'(OSC_STATIC_CYC - 1)) begin
				ext_osc_mode  <= 1'b0;
			end else begin
				quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
			end
		end
	end
endmodule : adcsr_freq_sel

// >>> adcsr_props.sv
// checker of the serial readout pin behaviour
`timescale 1ns/1ns
module adcsr_props #(
	parameter int CONV_CYC_60_P = 200
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pins and status
	input wire logic select_low_input,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	input wire logic shift_clk_out,
	input wire logic shift_clk_oe,
	input wire logic shift_clk_pullup_en,
	input wire logic conversion_pending_flag,
	input wire logic sleep_active
);
	int cnt_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence out_ph;
		serial_result_oe && !conversion_pending_flag && !sleep_active;
	endsequence
	sequence sel_hi;
		select_low_input [*4];
	endsequence
	always_ff @(posedge clock) begin
		cnt_reg <= (rst || !conversion_pending_flag) ? 0 : cnt_reg + 1;
	end
	a_oe_on_select: assert property ($fell(select_low_input) |-> ##[1:4] serial_result_oe)
		else $error("output not enabled");
	a_oe_off_high: assert property (sel_hi |-> !serial_result_oe)
		else $error("output not released");
	a_sleep_entry: assert property (sel_hi ##0 $fell(conversion_pending_flag) |-> ##[0:1] sleep_active)
		else $error("no sleep after conversion");
	a_status_busy: assert property (serial_result_oe && conversion_pending_flag |-> serial_result_out)
		else $error("busy status wrong");
	a_status_sleep: assert property (serial_result_oe && sleep_active |-> !serial_result_out)
		else $error("sleep status wrong");
	a_pullup_int: assert property (shift_clk_oe |-> shift_clk_pullup_en)
		else $error("pull-up off while driving");
	a_clk_steady: assert property ($rose(shift_clk_out) && shift_clk_oe |=> $stable(shift_clk_out) [*8])
		else $error("shift clock too fast");
	a_abort_restart: assert property (out_ph ##1 sel_hi |=> conversion_pending_flag || sleep_active)
		else $error("transfer not aborted");
	a_conv_length: assert property ($fell(conversion_pending_flag) |-> cnt_reg >= CONV_CYC_60_P - 2)
		else $error("conversion too short");
endmodule : adcsr_props
bind adcsr_top adcsr_props #(.CONV_CYC_60_P(CONV_CYC_60_P)) u_props (.clock(clock), .rst(rst),
	.select_low_input(select_low_input), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
	.shift_clk_out(shift_clk_out), .shift_clk_oe(shift_clk_oe), .shift_clk_pullup_en(shift_clk_pullup_en),
	.conversion_pending_flag(conversion_pending_flag), .sleep_active(sleep_active));

// >>> adcsr_top.sv
// conversion sequencer and three-wire serial readout
// How it works
// R1: select low enables output, wakes device
// R2: sleep after conversion while select high
// R3: select rising during output, after the first shift clock, restarts conversion
// R4: output released while select high
// R5: status shown during conversion and sleep
// R6: internal mode drives shift clock
// R7: external mode host drives shift clock
// R8: pull-up enabled in internal mode
// R9: mode sampled at reset, select falling
// R10: control high gives 50 Hz timing
// R11: control low gives 60 Hz timing
// R12: toggling control pin is system clock
// R13: 24-bit frame, status then result
// R14: change data on falling shift edge
// R15: first bit is conversion pending flag
// R16: output ends after 24 bits, restarts
// R17: early select high keeps result, sleeps
// R18: high shift clock level selects internal
`timescale 1ns/1ns
module adcsr_top #(
	parameter int CONV_CYC_60_P   = adcsr_pkg::CONV_CYC_60,
	parameter int CONV_CYC_50_P   = adcsr_pkg::CONV_CYC_50,
	parameter int EXT_CONV_EDGE_P = adcsr_pkg::EXT_CONV_EDGES
) (
	// clock and reset
	input  wire logic                              clock,
	input  wire logic                              rst,
	// host pins
	input  wire logic                              select_low_input,
	input  wire logic                              shift_clk_in,
	output logic                                   shift_clk_out,
	output logic                                   shift_clk_oe,
	output logic                                   shift_clk_pullup_en,
	output logic                                   serial_result_out,
	output logic                                   serial_result_oe,
	input  wire logic                              notch_freq_control,
	// converter core
	input  wire logic [adcsr_pkg::RESULT_BITS-1:0] conv_result,
	input  wire logic                              conv_sign,
	output logic                                   conversion_pending_flag,
	output logic                                   sleep_active
);
	import adcsr_pkg::*;

	adcsr_state_type        state_reg;
	adcsr_state_type        state_next;
	logic                   cs_s1_reg;
	logic                   cs_s2_reg;
	logic                   cs_s3_reg;
	logic                   sck_s1_reg;
	logic                   sck_s2_reg;
	logic                   sck_s3_reg;
	logic                   internal_mode_reg;
	logic [1:0]             strap_cnt_reg;
	logic [CONV_CNT_W-1:0]  conv_cnt_reg;
	logic [DIV_CNT_W-1:0]   div_cnt_reg;
	logic [FRAME_BITS-1:0]  frame_reg;
	logic [4:0]             bit_cnt_reg;
	logic                   started_reg;
	logic                   ext_osc_mode;
	logic                   notch_50hz;
	logic                   osc_edge;
	logic                   tick;
	logic                   conv_done;
	logic                   half_done;
	logic                   rise_ev;
	logic                   fall_ev;
	logic                   cs_rise;
	logic                   cs_fall;
	logic [CONV_CNT_W-1:0]  conv_limit;

	adcsr_freq_sel u_freq_sel (
		.clock              (clock),
		.rst                (rst),
		.notch_freq_control (notch_freq_control),
		.ext_osc_mode       (ext_osc_mode),
		.notch_50hz         (notch_50hz),
		.osc_edge           (osc_edge)
	);

	// pin synchronisers
	always_ff @(posedge clock) begin
		cs_s1_reg  <= select_low_input;
		cs_s2_reg  <= cs_s1_reg;
		cs_s3_reg  <= cs_s2_reg;
		sck_s1_reg <= shift_clk_in;
		sck_s2_reg <= sck_s1_reg;
		sck_s3_reg <= sck_s2_reg;
	end

	// events
	always_comb begin
		cs_rise = cs_s2_reg && !cs_s3_reg;
		cs_fall = !cs_s2_reg && cs_s3_reg;
		tick    = ext_osc_mode ? osc_edge : 1'b1; // R12
		if (ext_osc_mode) begin
			conv_limit = CONV_CNT_W'(EXT_CONV_EDGE_P - 1); // R12
		end else if (notch_50hz) begin
			conv_limit = CONV_CNT_W'(CONV_CYC_50_P - 1); // R10
		end else begin
			conv_limit = CONV_CNT_W'(CONV_CYC_60_P - 1); // R11
		end
		// limit may drop mid-conversion when the clock source changes
		conv_done = (state_reg == ADCSR_CONVERT) && tick && (conv_cnt_reg >= conv_limit);
		half_done = tick && (div_cnt_reg == (ext_osc_mode ? DIV_CNT_W'(EXT_ISCK_HALF - 1)
			: DIV_CNT_W'(ISCK_HALF_CYC - 1)));
		if (internal_mode_reg) begin
			rise_ev = (state_reg == ADCSR_OUTPUT) && half_done && !shift_clk_out; // R6
			fall_ev = (state_reg == ADCSR_OUTPUT) && half_done && shift_clk_out;
		end else begin
			rise_ev = (state_reg == ADCSR_OUTPUT) && sck_s2_reg && !sck_s3_reg; // R7
			fall_ev = (state_reg == ADCSR_OUTPUT) && !sck_s2_reg && sck_s3_reg;
		end
	end

	// state sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ADCSR_CONVERT: begin
				if (conv_done) begin
					state_next = cs_s2_reg ? ADCSR_SLEEP : ADCSR_OUTPUT; // R2
				end
			end
			ADCSR_SLEEP: begin
				if (!cs_s2_reg) begin
					state_next = ADCSR_OUTPUT; // R1
				end
			end
			ADCSR_OUTPUT: begin
				if (cs_rise) begin
					state_next = started_reg ? ADCSR_CONVERT : ADCSR_SLEEP; // R3 R17
				end else if (rise_ev && bit_cnt_reg == LAST_BIT_IDX) begin
					state_next = ADCSR_CONVERT; // R16
				end
			end
			default: state_next = ADCSR_CONVERT;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= ADCSR_CONVERT;
		end else begin
			state_reg <= state_next;
		end
	end

	// serial clock mode strap
	always_ff @(posedge clock) begin
		if (rst) begin
			strap_cnt_reg     <= '0;
			internal_mode_reg <= 1'b1;
		end else if (strap_cnt_reg != STRAP_SETTLE) begin
			strap_cnt_reg     <= strap_cnt_reg + 1'b1;
			internal_mode_reg <= sck_s2_reg; // R9 R18
		end else if (cs_fall && state_reg != ADCSR_OUTPUT) begin
			internal_mode_reg <= sck_s2_reg; // R9 R18
		end
	end

	// conversion timer
	always_ff @(posedge clock) begin
		if (rst || state_reg != ADCSR_CONVERT) begin
			conv_cnt_reg <= '0;
		end else if (tick) begin
			conv_cnt_reg <= conv_cnt_reg + 1'b1;
		end
	end

	// internal shift clock generator
	always_ff @(posedge clock) begin
		if (rst) begin
			div_cnt_reg   <= '0;
			shift_clk_out <= 1'b1;
		end else if (state_reg != ADCSR_OUTPUT || state_next != ADCSR_OUTPUT) begin
			div_cnt_reg   <= '0;
			shift_clk_out <= !(internal_mode_reg && state_next == ADCSR_OUTPUT); // R6
		end else if (half_done) begin
			div_cnt_reg   <= '0;
			shift_clk_out <= !shift_clk_out; // R6
		end else if (tick) begin
			div_cnt_reg   <= div_cnt_reg + 1'b1;
		end
	end

	// result frame and bit count
	always_ff @(posedge clock) begin
		if (rst) begin
			frame_reg   <= '0;
			bit_cnt_reg <= '0;
			started_reg <= 1'b0;
		end else if (conv_done) begin
			frame_reg   <= {1'b0, FRAME_FILL_BIT, conv_sign, conv_result}; // R13 R15
			bit_cnt_reg <= '0;
			started_reg <= 1'b0;
		end else if (state_reg != ADCSR_OUTPUT) begin
			bit_cnt_reg <= '0;
			started_reg <= 1'b0;
		end else begin
			if (rise_ev) begin
				started_reg <= 1'b1; // R17
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
			end
			if (fall_ev && started_reg) begin
				frame_reg <= {frame_reg[FRAME_MSB-1:0], 1'b0}; // R14 R13
			end
		end
	end

	// pin drivers and status
	always_ff @(posedge clock) begin
		if (rst) begin
			serial_result_out       <= 1'b1;
			serial_result_oe        <= 1'b0;
			shift_clk_oe            <= 1'b0;
			shift_clk_pullup_en     <= 1'b1;
			conversion_pending_flag <= 1'b1;
			sleep_active            <= 1'b0;
		end else begin
			serial_result_oe        <= !cs_s2_reg; // R1 R4
			shift_clk_oe            <= internal_mode_reg && state_next == ADCSR_OUTPUT; // R6 R7
			shift_clk_pullup_en     <= internal_mode_reg; // R8
			conversion_pending_flag <= state_next == ADCSR_CONVERT; // R15
			sleep_active            <= state_next == ADCSR_SLEEP; // R2
			// status follows the state being entered, no stale data bit
			if (state_reg == ADCSR_OUTPUT && state_next == ADCSR_OUTPUT) begin
				serial_result_out <= frame_reg[FRAME_MSB]; // R14
			end else begin
				serial_result_out <= state_next == ADCSR_CONVERT; // R5 R15
			end
		end
	end
endmodule : adcsr_top

// >>> adcsr_top_test.sv
// bench of the serial readout block against a host model
`timescale 1ns/1ns
module adcsr_top_test;
	import adcsr_pkg::*;
	localparam int          C60      = 200;
	localparam int          C50      = 300;
	localparam int          CEXT     = 50;
	localparam int          OSC_HALF = 4;
	logic                   clock, rst, select_low_input, notch_freq_control, conv_sign, ext, done;
	logic [RESULT_BITS-1:0] conv_result;
	logic                   shift_clk_out, shift_clk_oe, shift_clk_pullup_en, serial_result_out, serial_result_oe;
	logic                   conversion_pending_flag, sleep_active;
	logic [23:0]            frame, fr;
	logic [23:0]            exp_q[$];
	logic [31:0]            seed;
	logic [2:0]             mon;
	wire                    sck_w, sdo_w, sck_drv;
	int                     failures, samples_checked;
	assign sck_w = shift_clk_oe ? shift_clk_out : ext ? sck_drv : 1'h1;
	assign sdo_w = serial_result_oe ? serial_result_out : !serial_result_out;
	assign mon = {serial_result_oe, conversion_pending_flag, sleep_active};
	adcsr_top #(.CONV_CYC_60_P(C60), .CONV_CYC_50_P(C50), .EXT_CONV_EDGE_P(CEXT)) dut (
		.clock(clock), .rst(rst), .select_low_input(select_low_input), .shift_clk_in(sck_w),
		.shift_clk_out(shift_clk_out), .shift_clk_oe(shift_clk_oe), .shift_clk_pullup_en(shift_clk_pullup_en),
		.serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
		.notch_freq_control(notch_freq_control), .conv_result(conv_result), .conv_sign(conv_sign),
		.conversion_pending_flag(conversion_pending_flag), .sleep_active(sleep_active));
	adcsr_host host (.clock(clock), .sck_wire(sck_w), .sdo_wire(sdo_w), .sck_drv(sck_drv), .frame(frame), .done(done));
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic final_report();
		if (failures == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [23:0] got, input logic [23:0] want);
		samples_checked++;
		if (got !== want) begin
			failures++;
			$display("CHECK FAILED at %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic wt(input int k, input logic v);
		for (int i = 0; mon[k] !== v; i++) begin
			if (i > 20000) begin
				failures++;
				final_report();
			end
			@(negedge clock);
		end
	endtask : wt
	task automatic roll(input bit upd);
		seed = xs(seed);
		conv_result = seed[20:0];
		conv_sign = seed[31];
		if (upd) fr = {2'h0, conv_sign, conv_result};
	endtask : roll
	task automatic rd(input int nb);
		select_low_input = 0;
		wt(2, 1);
		wt(1, 0);
		exp_q.push_back(fr >> (24 - nb));
		host.xfer(nb, ext);
		roll(1);
	endtask : rd
	task automatic conv_len(input int lo, input int hi, input bit osc);
		int n;
		for (n = 0; !sleep_active && n < 9999; n++) begin
			if (osc && n % OSC_HALF == 0) notch_freq_control = !notch_freq_control;
			@(negedge clock);
		end
		chk(n >= lo && n <= hi, 1);
	endtask : conv_len
	always @(posedge clock) if (done) chk(frame, exp_q.pop_front());
	initial begin
		rst = 1;
		select_low_input = 1;
		notch_freq_control = 1;
		ext = 1;
		seed = 32'h26BA;
		roll(1);
		repeat (5) @(negedge clock);
		rst = 0;
		conv_len(C50 - 4, C50 + 8, 0);
		repeat (40) @(negedge clock);
		chk(sleep_active, 1);
		rd(24);
		repeat (6) @(negedge clock);
		chk(serial_result_out, 1);
		rd(24);
		select_low_input = 1;
		wt(0, 1);
		select_low_input = 0;
		wt(2, 1);
		select_low_input = 1;
		roll(0);
		repeat (9) @(negedge clock);
		chk(sleep_active, 1);
		rd(24);
		select_low_input = 1;
		wt(0, 1);
		rd(5);
		select_low_input = 1;
		repeat (6) @(negedge clock);
		chk(conversion_pending_flag, 1);
		notch_freq_control = 0;
		repeat (4500) @(negedge clock);
		rd(24);
		select_low_input = 1;
		conv_len(C60 - 4, C60 + 8, 0);
		rd(24);
		select_low_input = 1;
		conv_len(2 * OSC_HALF * (CEXT - 4), 2 * OSC_HALF * CEXT + 16, 1);
		ext = 0;
		repeat (3) @(negedge clock);
		rd(24);
		chk(shift_clk_pullup_en, 1);
		select_low_input = 1;
		repeat (6) @(negedge clock);
		chk(shift_clk_oe, 0);
		final_report();
	end
endmodule : adcsr_top_test
